// *** logic/sdc_debug.sv ***
// Single-pin debug controller: autobaud link, debug mode and debug counter
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_debug #(
  parameter int ERR_BREAK_CYC = `SDC_ERR_BREAK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dbg_in,
  output logic dbg_out,
  output logic dbg_oe,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic baud_locked,
  input wire logic ctl_dbg_set,
  input wire logic ctl_dbg_clr,
  input wire logic ctl_brk_en,
  input wire logic ctl_brk_loop,
  input wire logic [1:0] ctl_cnt_mode,
  input wire logic cnt_wr,
  input wire logic [15:0] cnt_wdata,
  output logic [15:0] cnt_value,
  input wire logic cpu_brk,
  input wire logic [15:0] cpu_pc,
  input wire logic stop_mode,
  output logic debug_mode_flag,
  output logic idle_status,
  output logic cmd_enable,
  output logic sys_reset_req
);
  localparam sdc_pkg::sdc_state_t RST_STATE = '{
    pin_s1: 1'b1, pin_s2: 1'b1, pin_prev: 1'b1, st: sdc_pkg::SDC_HUNT,
    tmr: `SDC_TMR_RST, low_cnt: `SDC_TMR_RST, bit_len: `SDC_BIT_LEN_RST,
    bit_idx: 4'h0, shreg: 10'h3FF, rx_data: 8'h00, rx_valid: 1'b0, rx_err: 1'b0,
    buf0: 8'h00, buf1: 8'h00, buf_cnt: 2'h0, tx_rdy: 1'b0, pin_lo: 1'b0,
    pin_oe: 1'b0, locked: 1'b0, dbg: 1'b0, idle: 1'b0, cmd_en: 1'b0,
    counter: `SDC_CNT_RST, boot: 2'h0, sysrst: 1'b0};

  logic [1:0] rst_sync_reg;
  logic rst_i_n;
  sdc_pkg::sdc_state_t s_reg;
  sdc_pkg::sdc_state_t s_next;
  logic line;
  logic [9:0] half_len;
  logic [12:0] break_len;
  logic [9:0] meas_div;
  logic brk_hit;
  logic enter;
  logic pop;
  logic push;
  sdc_pkg::sdc_cnt_mode_t cmode;

  // ==========================================================
  // Reset release
  // Release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync_reg[1];

  // ==========================================================
  // Derived values
  assign line = s_reg.pin_s2;
  assign half_len = {1'b0, s_reg.bit_len[9:1]};
  assign break_len = {s_reg.bit_len, 3'h0} + {3'h0, s_reg.bit_len};
  assign meas_div = s_reg.tmr[12:`SDC_SYNC_SHIFT];
  assign cmode = sdc_pkg::sdc_cnt_mode_t'(ctl_cnt_mode);
  assign brk_hit = cpu_brk & ctl_brk_en;
  assign push = tx_valid & s_reg.tx_rdy;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    pop = 1'b0;
    enter = 1'b0;
    s_next.rx_valid = 1'b0;
    s_next.rx_err = 1'b0;
    s_next.sysrst = 1'b0;
    // Pin synchroniser; only the second stage is read
    s_next.pin_s1 = dbg_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_prev = s_reg.pin_s2;
    // Own drive excluded so a zero-heavy character is not seen as a break
    if (!line && !s_reg.pin_oe) begin
      if (s_reg.low_cnt != 13'h1FFF) begin
        s_next.low_cnt = s_reg.low_cnt + 13'h0001;
      end
    end else begin
      s_next.low_cnt = `SDC_TMR_RST;
    end
    case (s_reg.st)
      sdc_pkg::SDC_HUNT: begin
        // Silent until the host's first falling edge
        s_next.locked = 1'b0;
        if (!line && s_reg.pin_prev) begin
          s_next.st = sdc_pkg::SDC_MEAS;
          s_next.tmr = 13'h0001;
        end
      end
      sdc_pkg::SDC_MEAS: begin
        // Eight low bit times, so one bit is the count shifted by three
        if (line) begin
          if (meas_div >= `SDC_MIN_DIV) begin
            s_next.bit_len = meas_div;
            s_next.locked = 1'b1;
            s_next.st = sdc_pkg::SDC_IDLE;
          end else begin
            s_next.st = sdc_pkg::SDC_HUNT;
          end
        end else if (s_reg.tmr > `SDC_MEAS_MAX) begin
          s_next.st = sdc_pkg::SDC_HOLD;
        end else begin
          s_next.tmr = s_reg.tmr + 13'h0001;
        end
      end
      sdc_pkg::SDC_IDLE: begin
        // Receive has priority so the line is never used both ways
        s_next.tmr = `SDC_TMR_RST;
        s_next.bit_idx = 4'h0;
        if (!line && s_reg.pin_prev) begin
          s_next.st = sdc_pkg::SDC_RX;
        end else if (s_reg.buf_cnt != 2'h0) begin
          pop = 1'b1;
          s_next.tmr = 13'h0001;
          s_next.shreg = {1'b1, s_reg.buf0, 1'b0};
          s_next.st = sdc_pkg::SDC_TX;
        end
      end
      sdc_pkg::SDC_RX: begin
        // First sample half a bit in, then one bit apart
        s_next.tmr = s_reg.tmr + 13'h0001;
        if (s_reg.tmr == {3'h0, (s_reg.bit_idx == 4'h0) ? half_len : s_reg.bit_len}) begin
          s_next.tmr = 13'h0001;
          s_next.shreg = {line, s_reg.shreg[9:1]};
          s_next.bit_idx = s_reg.bit_idx + 4'h1;
          if (s_reg.bit_idx == `SDC_FRAME_BITS) begin
            if (line) begin
              s_next.rx_data = s_reg.shreg[9:2];
              s_next.rx_valid = 1'b1;
              s_next.st = sdc_pkg::SDC_IDLE;
            end else begin
              s_next.st = sdc_pkg::SDC_ERRBRK;
              s_next.tmr = `SDC_TMR_RST;
            end
          end
        end
      end
      sdc_pkg::SDC_TX: begin
        // A released high bit read back low means the host is driving
        s_next.tmr = s_reg.tmr + 13'h0001;
        if (s_reg.tmr == {3'h0, half_len} && s_reg.shreg[0] && !line) begin
          s_next.st = sdc_pkg::SDC_ERRBRK;
          s_next.tmr = `SDC_TMR_RST;
        end else if (s_reg.tmr == {3'h0, s_reg.bit_len}) begin
          // Restart at one so a sent bit lasts bit_len cycles, as a received one
          s_next.tmr = 13'h0001;
          s_next.shreg = {1'b1, s_reg.shreg[9:1]};
          s_next.bit_idx = s_reg.bit_idx + 4'h1;
          if (s_reg.bit_idx == `SDC_FRAME_BITS) begin
            s_next.st = sdc_pkg::SDC_IDLE;
          end
        end
      end
      sdc_pkg::SDC_ERRBRK: begin
        // Answering break; open drain only lengthens a host break
        s_next.locked = 1'b0;
        s_next.tmr = s_reg.tmr + 13'h0001;
        if (s_reg.tmr == 13'(ERR_BREAK_CYC - 1)) begin
          s_next.st = sdc_pkg::SDC_HOLD;
        end
      end
      sdc_pkg::SDC_HOLD: begin
        // Link kept in reset while the break lasts
        s_next.locked = 1'b0;
        if (line) begin
          s_next.st = sdc_pkg::SDC_HUNT;
        end
      end
      default: begin
        s_next.st = sdc_pkg::SDC_HUNT;
      end
    endcase
    // Long low from the host overrides any locked state but the answering break, even our own sending
    if (s_reg.locked && s_reg.low_cnt >= break_len &&
        s_reg.st != sdc_pkg::SDC_ERRBRK && s_reg.st != sdc_pkg::SDC_HOLD) begin
      s_next.st = sdc_pkg::SDC_HOLD;
    end
    if (s_next.st == sdc_pkg::SDC_ERRBRK && s_reg.st != sdc_pkg::SDC_ERRBRK) begin
      s_next.rx_err = 1'b1;
    end

    // Two-entry transmit buffer; flushed when an error aborts the command
    if (pop) begin
      s_next.buf0 = s_reg.buf1;
    end
    if (push) begin
      if (s_reg.buf_cnt - {1'b0, pop} == 2'h0) begin
        s_next.buf0 = tx_data;
      end else begin
        s_next.buf1 = tx_data;
      end
    end
    s_next.buf_cnt = s_reg.buf_cnt + {1'b0, push} - {1'b0, pop};
    if (s_next.st == sdc_pkg::SDC_ERRBRK) begin
      s_next.buf_cnt = 2'h0;
    end
    s_next.tx_rdy = s_next.buf_cnt < `SDC_BUF_DEPTH;
    s_next.pin_oe = (s_next.st == sdc_pkg::SDC_ERRBRK) ||
                    (s_next.st == sdc_pkg::SDC_TX && !s_next.shreg[0]);

    // Strap: pin sampled once the synchroniser holds real pin values
    if (s_reg.boot != `SDC_BOOT_SAMPLE + 2'h1) begin
      s_next.boot = s_reg.boot + 2'h1;
    end
    // Debug mode entry sources; set wins over a clear in the same cycle
    if (ctl_dbg_set) begin
      enter = 1'b1;
    end
    if (s_reg.boot == `SDC_BOOT_SAMPLE && !line) begin
      enter = 1'b1;
    end
    if (brk_hit && !ctl_brk_loop) begin
      enter = 1'b1;
    end
    if (!s_reg.dbg && cmode == sdc_pkg::SDC_CNT_PC && cpu_pc == s_reg.counter) begin
      enter = 1'b1;
    end
    if (!s_reg.dbg && cmode == sdc_pkg::SDC_CNT_DOWN &&
        s_reg.counter == `SDC_CNT_ZERO_NEXT) begin
      enter = 1'b1;
    end
    s_next.dbg = enter | (s_reg.dbg & ~ctl_dbg_clr);
    // Loop on break: CPU keeps serving interrupts while this is shown
    if (s_next.dbg || !ctl_brk_en) begin
      s_next.idle = 1'b0;
    end else if (brk_hit && ctl_brk_loop) begin
      s_next.idle = 1'b1;
    end
    s_next.cmd_en = s_next.dbg & ~s_next.idle;

    // Debug counter
    if (s_reg.dbg && cnt_wr) begin
      s_next.counter = cnt_wdata;
    end else if (s_reg.dbg && !s_next.dbg && cmode == sdc_pkg::SDC_CNT_UP) begin
      s_next.counter = `SDC_CNT_RST;
    end else if (!s_reg.dbg) begin
      // Count-down takes its last step on entry so the register shows zero
      if (cmode == sdc_pkg::SDC_CNT_UP && !s_next.dbg && s_reg.counter != `SDC_CNT_MAX) begin
        s_next.counter = s_reg.counter + 16'h0001;
      end else if (cmode == sdc_pkg::SDC_CNT_DOWN && s_reg.counter != `SDC_CNT_RST) begin
        s_next.counter = s_reg.counter - 16'h0001;
      end
    end
    // Pin low during stop mode restarts the whole chip
    s_next.sysrst = stop_mode & ~line;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs, each straight from the state register
  assign dbg_out = s_reg.pin_lo;
  assign dbg_oe = s_reg.pin_oe;
  assign rx_data = s_reg.rx_data;
  assign rx_valid = s_reg.rx_valid;
  assign rx_err = s_reg.rx_err;
  assign tx_ready = s_reg.tx_rdy;
  assign baud_locked = s_reg.locked;
  assign cnt_value = s_reg.counter;
  // CPU stops fetch, leaves halt and refreshes the watchdog on this flag
  assign debug_mode_flag = s_reg.dbg;
  assign idle_status = s_reg.idle;
  assign cmd_enable = s_reg.cmd_en;
  assign sys_reset_req = s_reg.sysrst;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_i_n);

  quiet_before_sync_a: assert property (
    (s_reg.st == sdc_pkg::SDC_HUNT || s_reg.st == sdc_pkg::SDC_MEAS) |-> !dbg_oe)
    else $error("pin driven before baud lock");
  start_bit_low_a: assert property (
    s_reg.st == sdc_pkg::SDC_IDLE ##1 s_reg.st == sdc_pkg::SDC_TX |-> dbg_oe)
    else $error("start bit not driven low");
  baud_program_a: assert property (
    s_reg.st == sdc_pkg::SDC_MEAS && line && meas_div >= `SDC_MIN_DIV
    |=> s_reg.st == sdc_pkg::SDC_IDLE && s_reg.bit_len == $past(meas_div))
    else $error("bit length not taken from sync");
  framing_err_a: assert property (
    s_reg.st == sdc_pkg::SDC_RX && s_reg.bit_idx == `SDC_FRAME_BITS && !line &&
    s_reg.tmr == {3'h0, s_reg.bit_len} |=> s_reg.st == sdc_pkg::SDC_ERRBRK && rx_err ##1 !rx_err)
    else $error("framing error missed");
  collision_err_a: assert property (
    s_reg.st == sdc_pkg::SDC_TX && s_reg.tmr == {3'h0, half_len} && s_reg.shreg[0] && !line
    |=> s_reg.st == sdc_pkg::SDC_ERRBRK)
    else $error("collision missed");
  err_break_a: assert property (
    $rose(s_reg.st == sdc_pkg::SDC_ERRBRK) |-> rx_err ##0 dbg_oe [*8])
    else $error("answering break not driven");
  err_break_end_a: assert property (
    s_reg.st == sdc_pkg::SDC_ERRBRK && s_reg.tmr == 13'(ERR_BREAK_CYC - 1)
    |=> s_reg.st == sdc_pkg::SDC_HOLD && !dbg_oe)
    else $error("answering break length wrong");
  hold_low_a: assert property (
    s_reg.st == sdc_pkg::SDC_HOLD && !line |=> s_reg.st == sdc_pkg::SDC_HOLD)
    else $error("released during host break");
  break_keeps_mode_a: assert property (
    s_reg.st == sdc_pkg::SDC_HOLD && s_reg.dbg && !ctl_dbg_clr |=> s_reg.dbg)
    else $error("host break left debug mode");
  brk_enter_a: assert property (
    brk_hit && !ctl_brk_loop |=> debug_mode_flag && !idle_status && cmd_enable)
    else $error("break did not enter debug");
  brk_loop_a: assert property (
    brk_hit && ctl_brk_loop && !s_reg.dbg && !enter |=> idle_status && !cmd_enable)
    else $error("loop on break not shown");
  cycle_count_a: assert property (
    cmode == sdc_pkg::SDC_CNT_UP && !s_reg.dbg && !enter && s_reg.counter != `SDC_CNT_MAX
    |=> cnt_value == $past(cnt_value) + 16'h0001)
    else $error("cycle counter not counting");
  count_clear_a: assert property (
    s_reg.dbg && !s_next.dbg && cmode == sdc_pkg::SDC_CNT_UP && !cnt_wr
    |=> cnt_value == `SDC_CNT_RST)
    else $error("cycle counter not cleared on exit");
  stop_reset_a: assert property (
    stop_mode && !line |=> sys_reset_req)
    else $error("stop-mode pin reset missed");

  lock_c: cover property (s_reg.st == sdc_pkg::SDC_MEAS ##1 s_reg.st == sdc_pkg::SDC_IDLE);
  rx_byte_c: cover property (rx_valid);
  tx_byte_c: cover property (s_reg.st == sdc_pkg::SDC_TX ##1 s_reg.st == sdc_pkg::SDC_IDLE);
  err_c: cover property (s_reg.st == sdc_pkg::SDC_ERRBRK ##1 s_reg.st == sdc_pkg::SDC_HOLD);
endmodule

// *** include/sdc_defs.svh ***
// Constants of the single-pin debug controller
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
`define SDC_FRAME_BITS 4'h9
`define SDC_SYNC_SHIFT 3
`define SDC_MIN_DIV 10'h004
`define SDC_MEAS_MAX 13'h1000
`define SDC_ERR_BREAK_CYC 4096
`define SDC_CNT_RST 16'h0000
`define SDC_CNT_MAX 16'hFFFF
`define SDC_CNT_ZERO_NEXT 16'h0001
`define SDC_BIT_LEN_RST 10'h000
`define SDC_TMR_RST 13'h0000
`define SDC_BOOT_SAMPLE 2'h2
`define SDC_BUF_DEPTH 2'h2
`endif

// *** include/sdc_pkg.sv ***
// Types of the single-pin debug controller
package sdc_pkg;
  // Serial link state, one-hot
  typedef enum logic [6:0] {
    SDC_HUNT = 7'h01,
    SDC_MEAS = 7'h02,
    SDC_IDLE = 7'h04,
    SDC_RX = 7'h08,
    SDC_TX = 7'h10,
    SDC_ERRBRK = 7'h20,
    SDC_HOLD = 7'h40
  } sdc_link_t;
  // Use of the debug counter
  typedef enum logic [1:0] {
    SDC_CNT_OFF = 2'h0,
    SDC_CNT_UP = 2'h1,
    SDC_CNT_DOWN = 2'h2,
    SDC_CNT_PC = 2'h3
  } sdc_cnt_mode_t;
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    sdc_link_t st;
    logic [12:0] tmr;
    logic [12:0] low_cnt;
    logic [9:0] bit_len;
    logic [3:0] bit_idx;
    logic [9:0] shreg;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_err;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [1:0] buf_cnt;
    logic tx_rdy;
    logic pin_lo;
    logic pin_oe;
    logic locked;
    logic dbg;
    logic idle;
    logic cmd_en;
    logic [15:0] counter;
    logic [1:0] boot;
    logic sysrst;
  } sdc_state_t;
endpackage

// *** tb/sdc_host.sv ***
// Host model of the single-pin debug link: framed send, line pulls, receiver
`timescale 1ns/1ps

module sdc_host #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk_sys,
  input wire logic pin,
  output logic host_oe
);
  // Received characters, stop bit above the data byte
  logic [8:0] rxq[$];
  logic [8:0] sh;
  int i;

  initial host_oe = 1'b0;

  // ==========================================
  // Sending side
  // Stop level is an argument so a framing fault can be forced
  task automatic send(input logic [7:0] b, input logic stop_bit);
    logic [9:0] fr;
    fr = {stop_bit, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      host_oe = !fr[k];
      repeat (BIT_CYC) @(posedge clk_sys);
      #1;
    end
    host_oe = 1'b0;
    // Idle gap so the device never sees two starts closer than a frame
    repeat (2 * BIT_CYC) @(posedge clk_sys);
    #1;
  endtask

  // Hold the line low for n cycles: break, collision or stop wake
  task automatic pull(input int n);
    host_oe = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1;
    host_oe = 1'b0;
  endtask

  // ==========================================
  // Receiving side
  // Mid-bit sampling; frames begun by our own drive are ignored
  always begin
    @(negedge pin);
    if (!host_oe) begin
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        sh[i] = pin;
      end
      rxq.push_back(sh);
      while (!pin) @(posedge clk_sys);
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the single-pin debug controller
`timescale 1ns/1ps

module tb;
  localparam int BIT_CYC = 32;
  localparam int ERRB = 64;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dbg_out, dbg_oe, rx_valid, rx_err, tx_ready, baud_locked, tx_valid, cnt_wr, cpu_brk;
  logic ctl_dbg_set, ctl_dbg_clr, ctl_brk_en, ctl_brk_loop, stop_mode, host_oe;
  logic debug_mode_flag, idle_status, cmd_enable, sys_reset_req, full_seen, srr_seen;
  logic [1:0] ctl_cnt_mode;
  logic [7:0] rx_data, tx_data;
  logic [15:0] cnt_wdata, cnt_value, cpu_pc, v1;
  logic [7:0] rq[$];
  logic [7:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  int errs = 0;
  int oe_cnt = 0;
  wire pin;

  // Open drain with pull-up: low while any party pulls
  assign pin = !(dbg_oe | host_oe);

  always #50 clk_sys = !clk_sys;

  sdc_debug #(.ERR_BREAK_CYC(ERRB)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .dbg_in(pin), .dbg_out(dbg_out), .dbg_oe(dbg_oe),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .baud_locked(baud_locked),
    .ctl_dbg_set(ctl_dbg_set), .ctl_dbg_clr(ctl_dbg_clr), .ctl_brk_en(ctl_brk_en),
    .ctl_brk_loop(ctl_brk_loop), .ctl_cnt_mode(ctl_cnt_mode), .cnt_wr(cnt_wr),
    .cnt_wdata(cnt_wdata), .cnt_value(cnt_value), .cpu_brk(cpu_brk), .cpu_pc(cpu_pc),
    .stop_mode(stop_mode), .debug_mode_flag(debug_mode_flag), .idle_status(idle_status),
    .cmd_enable(cmd_enable), .sys_reset_req(sys_reset_req));

  sdc_host #(.BIT_CYC(BIT_CYC)) i_host (.clk_sys(clk_sys), .pin(pin), .host_oe(host_oe));

  // ==========================================
  // Monitors: one-cycle pulses are caught at the edge they stand for
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) rq.push_back(rx_data);
    if (rx_err === 1'b1) errs++;
    if (dbg_oe === 1'b1) oe_cnt++;
    if (tx_valid === 1'b1 && tx_ready === 1'b0) full_seen = 1'b1;
    if (sys_reset_req === 1'b1) srr_seen = 1'b1;
  end

  // ==========================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tmo();
    failures++;
    $display("unexpected wait: expected completion, seen timeout");
    finish_test();
  endtask

  task automatic endt(input string n);
    $display("test %s finished", n);
  endtask

  // Bounded wait: 0 bytes at the device, 1 characters at the host, 2 device drive
  task automatic wait_for(input int what, input int n);
    int k;
    for (k = 0; k < 4000; k++) begin
      if (what == 0 && rq.size() >= n) break;
      if (what == 1 && i_host.rxq.size() >= n) break;
      if (what == 2 && dbg_oe === 1'b1) break;
      step(1);
    end
    if (k == 4000) tmo();
  endtask

  // Offer one byte; held until ready is sampled high, valid left up for bursts
  task automatic txb(input logic [7:0] b);
    int k;
    tx_data = b;
    tx_valid = 1'b1;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk_sys);
      if (tx_ready === 1'b1) break;
    end
    #1;
    if (k == 2000) tmo();
  endtask

  task automatic ctl(input logic set, input logic clr);
    ctl_dbg_set = set;
    ctl_dbg_clr = clr;
    step(1);
    ctl_dbg_set = 1'b0;
    ctl_dbg_clr = 1'b0;
    step(1);
  endtask

  task automatic wr(input logic [15:0] d);
    cnt_wdata = d;
    cnt_wr = 1'b1;
    step(1);
    cnt_wr = 1'b0;
    step(1);
  endtask

  task automatic hit();
    cpu_brk = 1'b1;
    step(1);
    cpu_brk = 1'b0;
    step(1);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {tx_valid, ctl_dbg_set, ctl_dbg_clr, ctl_brk_en, ctl_brk_loop, cnt_wr, cpu_brk} = '0;
    {stop_mode, full_seen, srr_seen} = '0;
    tx_data = 8'h00;
    ctl_cnt_mode = 2'h0;
    cnt_wdata = 16'h0000;
    cpu_pc = 16'h0000;
    #1;
    // Host holds the pin low across reset release
    fork
      i_host.pull(22);
    join_none
    step(12);
    rst_n = 1'b1;
    step(15);
    chk("strap debug mode", 16'h0001, {15'h0000, debug_mode_flag});
    ctl(1'b0, 1'b1);
    chk("debug mode cleared", 16'h0000, {15'h0000, debug_mode_flag});
    endt("strap");
    // Byte offered before lock must wait for the sync character
    txb(8'h5A);
    tx_valid = 1'b0;
    step(100);
    chk("silent before sync", 16'h0000, oe_cnt[15:0]);
    i_host.send(8'h80, 1'b1);
    chk("locked", 16'h0001, {15'h0000, baud_locked});
    wait_for(1, 1);
    exp_q = '{8'h5A, 8'h11, 8'h22, 8'h33};
    full_seen = 1'b0;
    txb(8'h11);
    txb(8'h22);
    txb(8'h33);
    tx_valid = 1'b0;
    wait_for(1, 4);
    chk("buffer refused", 16'h0001, {15'h0000, full_seen});
    foreach (exp_q[j]) chk("host char", {7'h00, 1'b1, exp_q[j]}, {7'h00, i_host.rxq[j]});
    i_host.rxq.delete();
    // Device is still in its stop bit; the host waits so the line is never shared
    step(BIT_CYC);
    endt("transmit");
    exp_q = '{8'hA5, 8'h3C, 8'h80, 8'hFF};
    foreach (exp_q[j]) i_host.send(exp_q[j], 1'b1);
    wait_for(0, 4);
    foreach (exp_q[j]) chk("received byte", {8'h00, exp_q[j]}, {8'h00, rq[j]});
    endt("receive");
    errs = 0;
    oe_cnt = 0;
    i_host.send(8'h55, 1'b0);
    step(ERRB + BIT_CYC);
    chk("framing error", 16'h0001, errs[15:0]);
    chk("answer break length", ERRB[15:0], oe_cnt[15:0]);
    chk("lock lost", 16'h0000, {15'h0000, baud_locked});
    endt("framing");
    i_host.send(8'h80, 1'b1);
    ctl(1'b1, 1'b0);
    errs = 0;
    i_host.pull(12 * BIT_CYC);
    step(4 * BIT_CYC);
    chk("break drops lock", 16'h0000, {15'h0000, baud_locked});
    chk("debug kept", 16'h0001, {15'h0000, debug_mode_flag});
    endt("host break");
    i_host.send(8'h80, 1'b1);
    txb(8'hFF);
    tx_valid = 1'b0;
    wait_for(2, 1);
    step(3 * BIT_CYC);
    oe_cnt = 0;
    i_host.pull(BIT_CYC);
    step(ERRB + 2 * BIT_CYC);
    chk("collision", 16'h0001, errs[15:0]);
    chk("collision break", ERRB[15:0], oe_cnt[15:0]);
    chk("pin data level", 16'h0000, {15'h0000, dbg_out});
    endt("collision");
    srr_seen = 1'b0;
    i_host.pull(8);
    chk("no reset request", 16'h0000, {15'h0000, srr_seen});
    stop_mode = 1'b1;
    i_host.pull(8);
    stop_mode = 1'b0;
    chk("stop wake reset", 16'h0001, {15'h0000, srr_seen});
    endt("stop");
    ctl(1'b0, 1'b1);
    hit();
    chk("break as no-op", 16'h0000, {15'h0000, debug_mode_flag});
    ctl_brk_en = 1'b1;
    ctl_brk_loop = 1'b1;
    hit();
    chk("looping", 16'h0002, {14'h0000, idle_status, debug_mode_flag});
    chk("commands refused", 16'h0000, {15'h0000, cmd_enable});
    ctl_brk_loop = 1'b0;
    hit();
    chk("stopped on break", 16'h0003, {14'h0000, debug_mode_flag, cmd_enable});
    endt("breakpoints");
    wr(16'h0040);
    chk("counter write", 16'h0040, cnt_value);
    ctl_cnt_mode = 2'h3;
    ctl(1'b0, 1'b1);
    chk("no match yet", 16'h0000, {15'h0000, debug_mode_flag});
    cpu_pc = 16'h0040;
    step(2);
    chk("pc match", 16'h0001, {15'h0000, debug_mode_flag});
    cpu_pc = 16'h0000;
    wr(16'h0003);
    ctl_cnt_mode = 2'h2;
    ctl(1'b0, 1'b1);
    step(6);
    chk("count to zero", 16'h0001, {15'h0000, debug_mode_flag});
    chk("count reached zero", 16'h0000, cnt_value);
    ctl_cnt_mode = 2'h0;
    ctl(1'b0, 1'b1);
    v1 = cnt_value;
    wr(16'h1234);
    chk("write outside debug", v1, cnt_value);
    ctl_cnt_mode = 2'h1;
    ctl(1'b1, 1'b0);
    wr(16'h0100);
    ctl(1'b0, 1'b1);
    chk("counter cleared", 16'h0001, {15'h0000, cnt_value < 16'h0003});
    step(20);
    ctl(1'b1, 1'b0);
    v1 = cnt_value;
    step(10);
    chk("counter stopped", v1, cnt_value);
    chk("cycles counted", 16'h0001, {15'h0000, v1 >= 16'h0012 && v1 <= 16'h0019});
    endt("counter");
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    step(6);
    chk("reset leaves debug", 16'h0000, {15'h0000, debug_mode_flag});
    endt("reset");
    finish_test();
  end
endmodule
